// ==== counter_array_pkg.sv ====
/*
  Shared constants for the counter array core: bus offsets, field
  positions, reset values, timebase codes and prescaler counts.
  Assumes a 25 MHz system clock and a byte-addressed Avalon-MM bus.
*/
package counter_array_pkg;
  // Bus widths and channel count
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_CH = 3;
  // Register byte offsets
  localparam logic [7:0] OFF_COUNT_LOW = 8'h00;
  localparam logic [7:0] OFF_COUNT_HIGH = 8'h04;
  localparam logic [7:0] OFF_MODE = 8'h08;
  localparam logic [7:0] OFF_CTRL = 8'h0C;
  localparam logic [7:0] OFF_IRQ = 8'h10;
  localparam logic [7:0] OFF_CH_BASE = 8'h20;
  localparam logic [7:0] OFF_CH_END = 8'h50;
  // Offsets inside one channel block of 16 bytes
  localparam logic [3:0] CH_MODE = 4'h0;
  localparam logic [3:0] CH_CMP_LOW = 4'h4;
  localparam logic [3:0] CH_CMP_HIGH = 4'h8;
  // Mode register fields
  localparam int MODE_IDLE_STOP = 7;
  localparam int MODE_WDT_EN = 6;
  localparam int MODE_TB_HI = 3;
  localparam int MODE_TB_LO = 1;
  localparam int MODE_OVF_IE = 0;
  localparam logic [7:0] MODE_RESET = 8'h40;
  // Control register fields; channel flags sit in the low bits
  localparam int CTRL_OVF = 7;
  localparam int CTRL_RUN = 6;
  // Interrupt gate register fields
  localparam int IRQ_GLOBAL = 0;
  localparam int IRQ_ARRAY = 1;
  // Channel mode register fields
  localparam int CM_PWM16 = 7;
  localparam int CM_ECOM = 6;
  localparam int CM_RISE = 5;
  localparam int CM_FALL = 4;
  localparam int CM_MAT = 3;
  localparam int CM_TOG = 2;
  localparam int CM_PWM = 1;
  localparam int CM_IE = 0;
  localparam logic [7:0] CM_RESET = 8'h00;
  localparam logic [7:0] CAP_ZERO_MASK = 8'h0E;
  // Timebase select codes
  localparam logic [2:0] TB_DIV12 = 3'h0;
  localparam logic [2:0] TB_DIV4 = 3'h1;
  localparam logic [2:0] TB_T0 = 3'h2;
  localparam logic [2:0] TB_EXT = 3'h3;
  localparam logic [2:0] TB_SYS = 3'h4;
  localparam logic [2:0] TB_OSC8 = 3'h5;
  // Prescaler terminal counts
  localparam logic [3:0] DIV12_LAST = 4'hB;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  localparam logic [2:0] OSC8_LAST = 3'h7;
  // Counter limits
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [7:0] LOW_MAX = 8'hFF;
  // Bus answer state
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_t;
endpackage

// ==== timebase_gen.sv ====
/*
  Timebase tick generator for the counter array.
  Assumes external pins and the external oscillator are asynchronous
  and are sampled here; timer 0 overflow is a same-clock pulse.
*/
`timescale 1ns/1ps
module timebase_gen (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [2:0] select_in,
  input wire logic timer0_overflow_in,
  input wire logic external_count_input_in,
  input wire logic ext_osc_in,
  output logic tick_out
);
  logic [3:0] pre_q; // Shared divide-by-12 / divide-by-4 prescaler
  logic [1:0] eci_sync_q; // External input synchroniser
  logic eci_prev_q; // Last synchronised external input
  logic [1:0] osc_sync_q; // Oscillator synchroniser
  logic osc_prev_q; // Last synchronised oscillator level
  logic [2:0] osc_div_q; // Oscillator edge counter
  logic eci_fall; // Falling edge seen on external input
  logic osc_rise; // Rising edge seen on oscillator
  logic osc_tick; // Every eighth oscillator rising edge

  // Free-running prescaler, 0..11
  always_ff @(posedge clk_in) begin
    if (rst_in || pre_q == counter_array_pkg::DIV12_LAST) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 4'h1;
    end
  end

  // Two flops before anything looks at the pins
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      eci_sync_q <= '0;
      eci_prev_q <= 1'b0;
      osc_sync_q <= '0;
      osc_prev_q <= 1'b0;
    end else begin
      eci_sync_q <= {eci_sync_q[0], external_count_input_in};
      eci_prev_q <= eci_sync_q[1];
      osc_sync_q <= {osc_sync_q[0], ext_osc_in};
      osc_prev_q <= osc_sync_q[1];
    end
  end

  assign eci_fall = eci_prev_q & ~eci_sync_q[1];
  assign osc_rise = osc_sync_q[1] & ~osc_prev_q;
  assign osc_tick = osc_rise && osc_div_q == counter_array_pkg::OSC8_LAST;

  // Divide the already synchronised oscillator by eight
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      osc_div_q <= '0;
    end else if (osc_rise) begin
      osc_div_q <= osc_div_q + 3'h1;
    end
  end

  // One-cycle tick from the selected source
  always_comb begin
    case (select_in)
      counter_array_pkg::TB_DIV12: tick_out = pre_q == counter_array_pkg::DIV12_LAST;
      counter_array_pkg::TB_DIV4: tick_out = pre_q[1:0] == counter_array_pkg::DIV4_LAST;
      counter_array_pkg::TB_T0: tick_out = timer0_overflow_in;
      counter_array_pkg::TB_EXT: tick_out = eci_fall;
      counter_array_pkg::TB_SYS: tick_out = 1'b1;
      counter_array_pkg::TB_OSC8: tick_out = osc_tick;
      default: tick_out = 1'b0; // Reserved codes never count
    endcase
  end
endmodule

// ==== counter_array_core.sv ====
/*
  Counter array core: 16-bit counter, timebase choice, byte reads that
  are coherent unless a carry into the high byte lands in a low-byte read's
  wait cycle, overflow and channel flags, interrupt gating and three
  capture/compare channels behind an Avalon-MM slave with waitrequest.
  Assumes pins are asynchronous to clk_in and that a port crossbar
  outside uses the channel output enables.
*/
// Chosen here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
// Summary of operation
// - Counter read as low and high bytes
// - Low read snapshots high byte for next read
// - Reads never disturb counting
// - Three-bit select picks count source
// - External input counts falling edges, limited rate
// - Oscillator synchronised, then divided by eight
// - Wrap to zero sets overflow flag
// - Overflow requests interrupt only when enabled
// - Overflow flag cleared only by software
// - Idle control low keeps counting in idle
// - Four flags set regardless of interrupt enables
// - Request is OR of gated flags
// - Channel enable bit zero gates its flag
// - Three independently configured channels
// - Channel line reaches pin via crossbar
// - Channel 2 watchdog after reset, writes restricted
// - Capture edge select, bits three-one clear
// - Comparator off stops toggle, PWM low
// - Match flag enable lets match set flag
// - Low compare write clears, high sets enable
module counter_array_core (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [counter_array_pkg::ADDR_W-1:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [counter_array_pkg::DATA_W-1:0] writedata_in,
  output logic [counter_array_pkg::DATA_W-1:0] readdata_out,
  output logic waitrequest_out,
  input wire logic cpu_idle_in,
  input wire logic timer0_overflow_in,
  input wire logic external_count_input_in,
  input wire logic ext_osc_in,
  input wire logic [counter_array_pkg::NUM_CH-1:0] crossbar_enable_in,
  input wire logic [counter_array_pkg::NUM_CH-1:0] channel_io_line_in,
  output logic [counter_array_pkg::NUM_CH-1:0] channel_io_line_out,
  output logic [counter_array_pkg::NUM_CH-1:0] channel_io_line_oe_out,
  output logic irq_request_out,
  output logic irq_out,
  output logic watchdog_active_out
);
  localparam int NCH = counter_array_pkg::NUM_CH;
  counter_array_pkg::bus_state_t bus_q; // Bus answer state
  logic [15:0] count_q; // The counter itself
  logic [7:0] snap_q; // High byte caught by a low-byte read
  logic [7:0] mode_q; // Array mode register
  logic run_q; // Counter run control
  logic ovf_q; // Overflow flag
  logic [NCH-1:0] chf_q; // Channel event flags
  logic [1:0] irqen_q; // Global and array interrupt gates
  logic [7:0] cm_q [NCH]; // Channel mode registers
  logic [15:0] cmp_q [NCH]; // Channel compare/capture values
  logic [NCH-1:0] out_q; // Channel output levels
  logic [NCH-1:0] io_s1_q, io_s2_q, io_prev_q; // Pin sampling
  logic [NCH-1:0] cap_hit, match_hit, flag_set; // Channel events
  logic tick; // Selected timebase pulse
  logic advance; // Counter steps this cycle
  logic wrap; // Counter wraps to zero this cycle
  logic low_wrap; // Low byte wraps this cycle
  logic req, take, rd_take, wr_take; // Bus request phases
  logic [7:0] wbyte; // Write data byte lane
  logic [31:0] rd_val; // Read value for this address

  // Channel index of a channel-block address, NCH when outside
  function automatic logic [1:0] chan_of(input logic [7:0] a);
    logic [7:0] rel;
    rel = a - counter_array_pkg::OFF_CH_BASE;
    if (a < counter_array_pkg::OFF_CH_BASE || a >= counter_array_pkg::OFF_CH_END) begin
      chan_of = 2'(NCH);
    end else begin
      chan_of = rel[5:4];
    end
  endfunction

  // True when a channel register at sub-offset s is addressed
  function automatic logic ch_hit(input logic [7:0] a, input int n, input logic [3:0] s);
    ch_hit = chan_of(a) == 2'(n) && a[3:0] == s;
  endfunction

  assign req = read_in | write_in;
  // One wait state: the request is taken on the second edge
  assign waitrequest_out = req && bus_q != counter_array_pkg::BUS_ACK;
  assign take = req && bus_q == counter_array_pkg::BUS_ACK;
  assign rd_take = take & read_in;
  assign wr_take = take & write_in;
  assign wbyte = writedata_in[7:0];

  // Bus answer sequencing
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      bus_q <= counter_array_pkg::BUS_IDLE;
    end else begin
      case (bus_q)
        counter_array_pkg::BUS_IDLE: bus_q <= req ? counter_array_pkg::BUS_ACK : counter_array_pkg::BUS_IDLE;
        counter_array_pkg::BUS_ACK: bus_q <= counter_array_pkg::BUS_IDLE;
        default: bus_q <= counter_array_pkg::BUS_IDLE;
      endcase
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_val = '0;
    case (address_in)
      counter_array_pkg::OFF_COUNT_LOW: rd_val[7:0] = count_q[7:0];
      counter_array_pkg::OFF_COUNT_HIGH: rd_val[7:0] = snap_q;
      counter_array_pkg::OFF_MODE: rd_val[7:0] = mode_q;
      counter_array_pkg::OFF_CTRL: begin
        rd_val[counter_array_pkg::CTRL_OVF] = ovf_q;
        rd_val[counter_array_pkg::CTRL_RUN] = run_q;
        rd_val[NCH-1:0] = chf_q;
      end
      counter_array_pkg::OFF_IRQ: rd_val[1:0] = irqen_q;
      default: begin
        for (int n = 0; n < NCH; n++) begin
          if (ch_hit(address_in, n, counter_array_pkg::CH_MODE)) begin
            rd_val[7:0] = cm_q[n];
          end
          if (ch_hit(address_in, n, counter_array_pkg::CH_CMP_LOW)) begin
            rd_val[7:0] = cmp_q[n][7:0];
          end
          if (ch_hit(address_in, n, counter_array_pkg::CH_CMP_HIGH)) begin
            rd_val[7:0] = cmp_q[n][15:8];
          end
        end
      end
    endcase
  end

  // Read data is registered in the wait cycle and stands when taken
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      readdata_out <= '0;
    end else if (read_in && bus_q == counter_array_pkg::BUS_IDLE) begin
      readdata_out <= rd_val;
    end
  end

  // High byte snapshot on a taken low-byte read
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      snap_q <= '0;
    end else if (rd_take && address_in == counter_array_pkg::OFF_COUNT_LOW) begin
      snap_q <= count_q[15:8];
    end
  end

  timebase_gen u_timebase (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .select_in(mode_q[counter_array_pkg::MODE_TB_HI:counter_array_pkg::MODE_TB_LO]),
    .timer0_overflow_in(timer0_overflow_in),
    .external_count_input_in(external_count_input_in),
    .ext_osc_in(ext_osc_in),
    .tick_out(tick)
  );

  // Idle only stops counting when the idle control bit is set
  assign advance = tick & run_q & ~(cpu_idle_in & mode_q[counter_array_pkg::MODE_IDLE_STOP]);
  assign wrap = advance && count_q == counter_array_pkg::COUNT_MAX;
  assign low_wrap = advance && count_q[7:0] == counter_array_pkg::LOW_MAX;

  // Counter: bus reads have no path into it
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      count_q <= '0;
    end else if (wr_take && address_in == counter_array_pkg::OFF_COUNT_LOW) begin
      count_q[7:0] <= wbyte;
    end else if (wr_take && address_in == counter_array_pkg::OFF_COUNT_HIGH) begin
      count_q[15:8] <= wbyte;
    end else if (advance) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // Mode register; watchdog active locks all but its enable bit
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mode_q <= counter_array_pkg::MODE_RESET;
    end else if (wr_take && address_in == counter_array_pkg::OFF_MODE) begin
      if (mode_q[counter_array_pkg::MODE_WDT_EN]) begin
        mode_q[counter_array_pkg::MODE_WDT_EN] <= wbyte[counter_array_pkg::MODE_WDT_EN];
      end else begin
        mode_q <= wbyte;
      end
    end
  end

  assign watchdog_active_out = mode_q[counter_array_pkg::MODE_WDT_EN];

  // Control: run bit and software-cleared flags, set wins
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      run_q <= 1'b0;
      ovf_q <= 1'b0;
      chf_q <= '0;
    end else begin
      if (wr_take && address_in == counter_array_pkg::OFF_CTRL) begin
        run_q <= wbyte[counter_array_pkg::CTRL_RUN];
        ovf_q <= wrap | wbyte[counter_array_pkg::CTRL_OVF];
        chf_q <= flag_set | wbyte[NCH-1:0];
      end else begin
        ovf_q <= ovf_q | wrap;
        chf_q <= chf_q | flag_set;
      end
    end
  end

  // Interrupt gate register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irqen_q <= '0;
    end else if (wr_take && address_in == counter_array_pkg::OFF_IRQ) begin
      irqen_q <= wbyte[1:0];
    end
  end

  // Combined request, then the processor-side gates
  always_comb begin
    irq_request_out = ovf_q & mode_q[counter_array_pkg::MODE_OVF_IE];
    for (int n = 0; n < NCH; n++) begin
      irq_request_out = irq_request_out | (chf_q[n] & cm_q[n][counter_array_pkg::CM_IE]);
    end
    irq_out = irq_request_out & irqen_q[counter_array_pkg::IRQ_GLOBAL] & irqen_q[counter_array_pkg::IRQ_ARRAY];
  end

  // Channel pin synchronisers and last level
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      io_s1_q <= '0;
      io_s2_q <= '0;
      io_prev_q <= '0;
    end else begin
      io_s1_q <= channel_io_line_in;
      io_s2_q <= io_s1_q;
      io_prev_q <= io_s2_q;
    end
  end

  // Capture and match events per channel
  always_comb begin
    for (int n = 0; n < NCH; n++) begin
      cap_hit[n] = (cm_q[n] & counter_array_pkg::CAP_ZERO_MASK) == 8'h00
        && !cm_q[n][counter_array_pkg::CM_ECOM]
        && ((cm_q[n][counter_array_pkg::CM_RISE] && io_s2_q[n] && !io_prev_q[n])
        || (cm_q[n][counter_array_pkg::CM_FALL] && !io_s2_q[n] && io_prev_q[n]));
      if (cm_q[n][counter_array_pkg::CM_PWM] && !cm_q[n][counter_array_pkg::CM_PWM16]) begin
        match_hit[n] = advance && cm_q[n][counter_array_pkg::CM_ECOM] && count_q[7:0] == cmp_q[n][7:0];
      end else begin
        match_hit[n] = advance && cm_q[n][counter_array_pkg::CM_ECOM] && count_q == cmp_q[n];
      end
      flag_set[n] = cap_hit[n] | (match_hit[n] & cm_q[n][counter_array_pkg::CM_MAT]);
    end
  end

  // Channel mode and compare registers, one block per channel
  always_ff @(posedge clk_in) begin
    for (int n = 0; n < NCH; n++) begin
      if (rst_in) begin
        cm_q[n] <= counter_array_pkg::CM_RESET;
        cmp_q[n] <= '0;
      end else begin
        // Watchdog channel is write-locked while the watchdog runs
        if (wr_take && !(n == NCH - 1 && watchdog_active_out)) begin
          if (ch_hit(address_in, n, counter_array_pkg::CH_MODE)) begin
            cm_q[n] <= wbyte;
          end
          if (ch_hit(address_in, n, counter_array_pkg::CH_CMP_LOW)) begin
            cm_q[n][counter_array_pkg::CM_ECOM] <= 1'b0;
          end
          if (ch_hit(address_in, n, counter_array_pkg::CH_CMP_HIGH)) begin
            cm_q[n][counter_array_pkg::CM_ECOM] <= 1'b1;
          end
        end
        if (cap_hit[n]) begin
          cmp_q[n] <= count_q;
        end else if (wr_take && !(n == NCH - 1 && watchdog_active_out)
          && ch_hit(address_in, n, counter_array_pkg::CH_CMP_LOW)) begin
          cmp_q[n][7:0] <= wbyte;
        end else if (wr_take && !(n == NCH - 1 && watchdog_active_out)
          && ch_hit(address_in, n, counter_array_pkg::CH_CMP_HIGH)) begin
          cmp_q[n][15:8] <= wbyte;
        end else if (low_wrap && cm_q[n][counter_array_pkg::CM_PWM]
          && !cm_q[n][counter_array_pkg::CM_PWM16]) begin
          cmp_q[n][7:0] <= cmp_q[n][15:8]; // 8-bit PWM reload
        end
      end
    end
  end

  // Channel output levels; comparator off forces PWM low
  always_ff @(posedge clk_in) begin
    for (int n = 0; n < NCH; n++) begin
      if (rst_in) begin
        out_q[n] <= 1'b0;
      end else if (cm_q[n][counter_array_pkg::CM_PWM] && !cm_q[n][counter_array_pkg::CM_TOG]) begin
        if (!cm_q[n][counter_array_pkg::CM_ECOM]) begin
          out_q[n] <= 1'b0;
        end else if (match_hit[n]) begin
          out_q[n] <= 1'b1;
        end else if (cm_q[n][counter_array_pkg::CM_PWM16] ? wrap : low_wrap) begin
          out_q[n] <= 1'b0;
        end
      end else if (cm_q[n][counter_array_pkg::CM_TOG] && match_hit[n]) begin
        out_q[n] <= ~out_q[n]; // match needs the comparator on
      end
    end
  end

  // Each channel drives its own line only through the crossbar
  always_comb begin
    for (int n = 0; n < NCH; n++) begin
      channel_io_line_out[n] = out_q[n];
      channel_io_line_oe_out[n] = crossbar_enable_in[n]
        && (cm_q[n][counter_array_pkg::CM_TOG] || cm_q[n][counter_array_pkg::CM_PWM]);
    end
  end
endmodule

// ==== counter_array_core_asserts.sv ====
/*
  Port checker for the counter array core: bus timing, read data
  holding, interrupt gating, output enables and watchdog reset state.
  Assumes it is bound onto counter_array_core and sees only its ports.
*/
`timescale 1ns/1ps
module counter_array_core_asserts (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [counter_array_pkg::DATA_W-1:0] readdata_out,
  input wire logic waitrequest_out,
  input wire logic [counter_array_pkg::NUM_CH-1:0] crossbar_enable_in,
  input wire logic [counter_array_pkg::NUM_CH-1:0] channel_io_line_oe_out,
  input wire logic irq_request_out,
  input wire logic irq_out,
  input wire logic watchdog_active_out
);
  // One domain, so one clock and one reset for every property
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  // A fresh request always sees one wait cycle first
  a_wait_first_cycle: assert property ((read_in || write_in) && !$past(read_in || write_in) |-> waitrequest_out)
    else $error("fresh request not held off");
  // Held request is answered after exactly one wait cycle
  a_wait_only_once: assert property ((read_in || write_in) && waitrequest_out ##1 (read_in || write_in) |-> !waitrequest_out)
    else $error("wait cycle longer than one");
  a_idle_no_wait: assert property (!(read_in || write_in) |-> !waitrequest_out)
    else $error("wait raised with no request");
  // Only the low byte of a register carries data
  a_upper_bytes_zero: assert property (readdata_out[31:8] == 24'h000000)
    else $error("upper read bytes not zero");
  // Read data only moves at the first edge of a read
  a_read_data_stands: assert property (!(read_in && waitrequest_out) |=> $stable(readdata_out))
    else $error("read data moved outside a read");
  a_irq_gated: assert property (irq_out |-> irq_request_out)
    else $error("interrupt without a request");
  a_oe_needs_crossbar: assert property ((channel_io_line_oe_out & ~crossbar_enable_in) == 3'h0)
    else $error("pin enabled without crossbar");
  a_watchdog_reset_on: assert property ($fell(rst_in) |-> watchdog_active_out)
    else $error("watchdog not active after reset");
  // Flags only fall through a taken software write
  a_flag_stays_set: assert property (irq_request_out && !(write_in && !waitrequest_out) |=> irq_request_out)
    else $error("request dropped without a write");
endmodule
bind counter_array_core counter_array_core_asserts i_counter_array_core_asserts (.clk_in, .rst_in, .read_in,
  .write_in, .readdata_out, .waitrequest_out, .crossbar_enable_in, .channel_io_line_oe_out, .irq_request_out,
  .irq_out, .watchdog_active_out);

// ==== counter_array_pins.sv ====
/*
  Model of the far side: external count input, external oscillator
  and the three channel pins. Assumes a free-running system clock.
*/
`timescale 1ns/1ps
module counter_array_pins (
  input wire logic clk_in,
  output logic ext_out,
  output logic osc_out,
  output logic [2:0] pins_out
);
  logic [2:0] ph_q = 3'h0; // Phase of the count input
  logic [1:0] osc_q = 2'h0; // Oscillator half-period count
  initial begin
    ext_out = 1'h1;
    osc_out = 1'h0;
    pins_out = 3'h0;
  end
  // Count input: one falling edge per eight cycles, under the quarter rate
  always @(posedge clk_in) begin
    ph_q <= ph_q + 3'h1;
    ext_out <= !ph_q[2];
  end
  // Oscillator runs free, six cycle period, well below half the clock
  always @(posedge clk_in) begin
    osc_q <= (osc_q == 2'h2) ? 2'h0 : osc_q + 2'h1;
    if (osc_q == 2'h2) begin
      osc_out <= !osc_out;
    end
  end
  // Pin level change, held four cycles so the edge is recognised
  task automatic pin_set(input int ch, input logic v);
    @(posedge clk_in);
    pins_out[ch] <= v;
    repeat (4) @(posedge clk_in);
  endtask
endmodule

// ==== counter_array_core_tb.sv ====
/*
  Self-checking bench for counter_array_core with the pin model.
  Assumes the package, design, checker and pin model compile first.
*/
`timescale 1ns/1ps
module counter_array_core_tb;
  logic clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic [7:0] address_in = 8'h00;
  logic read_in = 1'h0;
  logic write_in = 1'h0;
  logic [31:0] writedata_in = 32'h0;
  logic [31:0] readdata_out;
  logic waitrequest_out;
  logic cpu_idle_in = 1'h0;
  logic t0_in = 1'h0; // Timer 0 overflow pulse, every eighth cycle
  logic [2:0] t0_cnt = 3'h0;
  logic ext_in, osc_in;
  logic [2:0] xbar_in = 3'h7;
  logic [2:0] pins_in, pins_out, pins_oe;
  logic irq_req, irq, wdt;
  logic [31:0] q; // Last bus answer
  int error_cnt = 0;
  int n_compared = 0;
  counter_array_core i_counter_array_core (.clk_in, .rst_in, .address_in, .read_in, .write_in, .writedata_in,
    .readdata_out, .waitrequest_out, .cpu_idle_in, .timer0_overflow_in(t0_in), .external_count_input_in(ext_in),
    .ext_osc_in(osc_in), .crossbar_enable_in(xbar_in), .channel_io_line_in(pins_in),
    .channel_io_line_out(pins_out), .channel_io_line_oe_out(pins_oe), .irq_request_out(irq_req),
    .irq_out(irq), .watchdog_active_out(wdt));
  counter_array_pins i_counter_array_pins (.clk_in, .ext_out(ext_in), .osc_out(osc_in), .pins_out(pins_in));
  always #20 clk_in = !clk_in;
  // Timer 0 overflow source, fixed period so counts are exact
  always @(posedge clk_in) begin
    t0_cnt <= t0_cnt + 3'h1;
    t0_in <= (t0_cnt == 3'h7);
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One Avalon transfer; held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
    @(posedge clk_in);
    address_in <= a;
    writedata_in <= {24'h0, d};
    write_in <= w;
    read_in <= !w;
    do @(posedge clk_in); while (waitrequest_out !== 1'h0);
    r = readdata_out;
    write_in <= 1'h0;
    read_in <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'h1, a, d, q);
  endtask
  // Read and compare; the caller's line names what is checked
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'h0, a, 8'h00, q);
    check(q, {24'h0, e});
  endtask
  // Zero the count, pick the mode and start it
  task automatic start(input logic [7:0] m);
    wr(8'h00, 8'h00);
    wr(8'h04, 8'h00);
    wr(8'h08, m);
    wr(8'h0C, 8'h40);
  endtask
  // Run window is 48 cycles: 45 idle or 15 reads, plus the stop write
  task automatic span(input logic [7:0] m, input logic rds, input logic [31:0] e);
    logic [31:0] lo;
    start(m);
    if (rds) begin
      repeat (15) bus(1'h0, 8'h00, 8'h00, lo);
    end else begin
      repeat (45) @(posedge clk_in);
    end
    wr(8'h0C, 8'h00);
    bus(1'h0, 8'h00, 8'h00, lo);
    bus(1'h0, 8'h04, 8'h00, q);
    check({16'h0, q[7:0], lo[7:0]}, e);
  endtask
  task automatic t_reset;
    rd(8'h08, 8'h40);
    rd(8'h0C, 8'h00);
    check({31'h0, wdt}, 32'h1);
    wr(8'h40, 8'h21);
    rd(8'h40, 8'h00);
    wr(8'h08, 8'h48);
    rd(8'h08, 8'h40);
    wr(8'h08, 8'h00);
    rd(8'h08, 8'h00);
    check({31'h0, wdt}, 32'h0);
    rd(8'hFC, 8'h00);
    $display("reset test done");
  endtask
  // Snapshot of the high byte taken only by a low byte read
  task automatic t_bytes;
    wr(8'h00, 8'h34);
    wr(8'h04, 8'h12);
    rd(8'h00, 8'h34);
    rd(8'h04, 8'h12);
    wr(8'h04, 8'h56);
    rd(8'h04, 8'h12);
    rd(8'h00, 8'h34);
    rd(8'h04, 8'h56);
    $display("byte test done");
  endtask
  // Every source over one window; periods divide 48 exactly
  task automatic t_timebase;
    logic [2:0] codes [7];
    logic [31:0] exps [7];
    codes = '{counter_array_pkg::TB_DIV12, counter_array_pkg::TB_DIV4, counter_array_pkg::TB_T0,
      counter_array_pkg::TB_EXT, counter_array_pkg::TB_SYS, counter_array_pkg::TB_OSC8, 3'h6};
    exps = '{32'h4, 32'hC, 32'h6, 32'h6, 32'h30, 32'h1, 32'h0};
    for (int i = 0; i < 7; i++) begin
      span({4'h0, codes[i], 1'h0}, 1'h0, exps[i]);
    end
    span(8'h08, 1'h1, 32'h30);
    cpu_idle_in <= 1'h1;
    span(8'h08, 1'h0, 32'h30);
    span(8'h88, 1'h0, 32'h0);
    cpu_idle_in <= 1'h0;
    $display("timebase test done");
  endtask
  task automatic t_overflow;
    wr(8'h08, 8'h08);
    wr(8'h00, 8'hFE);
    wr(8'h04, 8'hFF);
    wr(8'h0C, 8'h40);
    @(posedge clk_in); // Wrap must land before read data is latched
    rd(8'h0C, 8'hC0);
    @(negedge clk_in);
    check({30'h0, irq_req, irq}, 32'h0);
    wr(8'h08, 8'h09);
    wr(8'h10, 8'h01);
    @(negedge clk_in);
    check({30'h0, irq_req, irq}, 32'h2);
    wr(8'h10, 8'h03);
    @(negedge clk_in);
    check({30'h0, irq_req, irq}, 32'h3);
    wr(8'h0C, 8'h40);
    @(negedge clk_in);
    check({30'h0, irq_req, irq}, 32'h0);
    wr(8'h0C, 8'h00);
    wr(8'h08, 8'h08);
    $display("overflow test done");
  endtask
  // Stopped count, so each capture must hold the same value
  task automatic t_capture;
    logic [7:0] modes [3];
    logic [7:0] b;
    modes = '{8'h20, 8'h11, 8'h31};
    wr(8'h00, 8'hCD);
    wr(8'h04, 8'hAB);
    for (int n = 0; n < 3; n++) begin
      b = 8'h20 + 8'(16 * n);
      wr(b, modes[n]);
      i_counter_array_pins.pin_set(n, 1'h1);
      i_counter_array_pins.pin_set(n, 1'h0);
      rd(8'h0C, 8'h01 << n);
      rd(b + 8'h04, 8'hCD);
      rd(b + 8'h08, 8'hAB);
      check({31'h0, irq_req}, {31'h0, n != 0});
      wr(8'h0C, 8'h00);
      wr(b, 8'h00);
    end
    $display("capture test done");
  endtask
  // Compare byte writes switch the comparator; match at count 5
  task automatic t_match;
    wr(8'h30, 8'h4C);
    wr(8'h34, 8'h05);
    rd(8'h30, 8'h0C);
    @(negedge clk_in);
    check({29'h0, pins_oe}, 32'h2);
    start(8'h08);
    repeat (10) @(posedge clk_in);
    rd(8'h0C, 8'h40);
    check({29'h0, pins_out}, 32'h0);
    wr(8'h0C, 8'h00);
    wr(8'h38, 8'h00);
    rd(8'h30, 8'h4C);
    start(8'h08);
    repeat (10) @(posedge clk_in);
    rd(8'h0C, 8'h42);
    check({29'h0, pins_out}, 32'h2);
    xbar_in <= 3'h5;
    @(negedge clk_in);
    check({29'h0, pins_oe}, 32'h0);
    @(posedge clk_in);
    xbar_in <= 3'h7;
    wr(8'h0C, 8'h00);
    wr(8'h30, 8'h00);
    $display("match test done");
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Main sequence after sixteen cycles of reset
  initial begin
    repeat (16) @(posedge clk_in);
    rst_in <= 1'h0;
    t_reset();
    t_bytes();
    t_timebase();
    t_overflow();
    t_capture();
    t_match();
    tally_and_finish();
  end
  // Hang guard, far beyond the thousand or so cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_in);
    error_cnt++;
    tally_and_finish();
  end
endmodule
